// ===== rx_adapt_modes_and_meters.sv
// Receive adaptation mode registers and performance meters
`timescale 1ns/1ps
`default_nettype none
module rx_adapt_modes_and_meters #(
  parameter int SAMPLE_W = 16,
  parameter int PD_W     = 16,
  parameter int DEPTH    = 16
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic [7:0]          addr,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  input  wire logic [7:0]          wr_data,
  output logic      [7:0]          rd_data,
  input  wire logic                sym_en,
  input  wire logic                meter_load,
  input  wire logic [SAMPLE_W-1:0] peak_in,
  output logic      [SAMPLE_W-1:0] peak_out,
  input  wire logic [SAMPLE_W-1:0] eq_err,
  input  wire logic [SAMPLE_W-1:0] gc_out,
  input  wire logic [SAMPLE_W-1:0] gc_target,
  output logic      [SAMPLE_W-1:0] gc_err,
  output logic                     gc_update_en,
  output logic      [1:0]          gc_step_shift,
  output logic                     eq_update_en,
  output logic                     eq_clear,
  output logic                     eq_last_only,
  output logic      [1:0]          eq_step_shift,
  input  wire logic [SAMPLE_W-1:0] ep_corr_in,
  output logic      [SAMPLE_W-1:0] ep_corr_out,
  output logic                     ep_update_en,
  output logic                     ep_clear,
  output logic      [1:0]          ep_step_shift,
  input  wire logic [PD_W-1:0]     phase_det,
  input  wire logic                adc_overflow,
  input  wire logic [SAMPLE_W-1:0] rx_sample,
  input  wire logic [SAMPLE_W-1:0] post_ec_sample
);
  localparam int PW = rx_meter_pkg::PHASE_W;
  localparam int LW = rx_meter_pkg::LEVEL_W;
  localparam int CW = rx_meter_pkg::CLIP_W;
  localparam int MW = rx_meter_pkg::MODE_W;
  localparam int DW = rx_meter_pkg::DELAY_W;

  typedef struct packed {
    logic [DW-1:0]                  delay;
    logic [MW-1:0]                  gc_mode;
    logic [MW-1:0]                  eq_mode;
    logic [MW-1:0]                  ep_mode;
    logic [DEPTH-1:0][SAMPLE_W-1:0] line;
    logic [SAMPLE_W-1:0]            peak_out;
    logic [SAMPLE_W-1:0]            gc_err;
    logic                           gc_update_en;
    logic [1:0]                     gc_step_shift;
    logic                           eq_update_en;
    logic                           eq_clear;
    logic                           eq_last_only;
    logic [1:0]                     eq_step_shift;
    logic [SAMPLE_W-1:0]            ep_corr_out;
    logic                           ep_update_en;
    logic                           ep_clear;
    logic [1:0]                     ep_step_shift;
    logic [PW-1:0]                  phase_acc;
    logic [PW-1:0]                  phase_mtr;
    logic [CW-1:0]                  clip_acc;
    logic [CW-1:0]                  clip_mtr;
    logic [LW-1:0]                  offset_acc;
    logic [LW-1:0]                  offset_mtr;
    logic [LW-1:0]                  mag_acc;
    logic [LW-1:0]                  mag_mtr;
    logic [LW-1:0]                  remote_acc;
    logic [LW-1:0]                  remote_mtr;
    logic [7:0]                     hi_snap;
    logic [7:0]                     rd_data;
  } state_s;

  state_s st;
  state_s next_st;

  function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] v);
    magnitude = v[SAMPLE_W-1] ? SAMPLE_W'(-v) : v;
  endfunction : magnitude

  function automatic logic [LW-1:0] sext_level(input logic [SAMPLE_W-1:0] v);
    sext_level = LW'($signed(v));
  endfunction : sext_level

  function automatic logic [7:0] meter_hi(input state_s s, input rx_meter_pkg::meter_e m);
    case (m)
      rx_meter_pkg::MTR_PHASE:  meter_hi = s.phase_mtr[PW-1 -: 8];
      rx_meter_pkg::MTR_OFFSET: meter_hi = s.offset_mtr[LW-1 -: 8];
      rx_meter_pkg::MTR_MAG:    meter_hi = s.mag_mtr[LW-1 -: 8];
      default:                  meter_hi = s.remote_mtr[LW-1 -: 8];
    endcase
  endfunction : meter_hi

  logic [SAMPLE_W-1:0] self_err;
  logic [PW-1:0]       phase_add;
  logic [LW-1:0]       mag_add;
  logic [LW-1:0]       remote_add;

  always_comb begin
    next_st    = st;
    self_err   = SAMPLE_W'(magnitude(gc_out) - gc_target);
    phase_add  = PW'($signed(phase_det));
    mag_add    = LW'(magnitude(rx_sample));
    remote_add = LW'(magnitude(post_ec_sample));

    if (wr_en) begin
      case (addr)
        rx_meter_pkg::ADDR_PEAK_PATH_DELAY:    next_st.delay   = wr_data[DW-1:0];
        rx_meter_pkg::ADDR_GAIN_CONTROL_MODES: next_st.gc_mode = wr_data[MW-1:0];
        rx_meter_pkg::ADDR_EQUALIZER_MODES:    next_st.eq_mode = wr_data[MW-1:0];
        rx_meter_pkg::ADDR_PREDICTOR_MODES:    next_st.ep_mode = wr_data[MW-1:0];
        default: ;
      endcase
    end

    if (sym_en) begin
      next_st.line     = {st.line[DEPTH-2:0], peak_in};
      next_st.peak_out = (st.delay == '0) ? peak_in : st.line[st.delay - 1'b1];
    end

    next_st.gc_err = st.gc_mode[rx_meter_pkg::GC_EQ_ERR_SOURCE] ? eq_err : self_err;
    next_st.gc_update_en = st.gc_mode[rx_meter_pkg::GC_ADAPT_COEFF];
    next_st.gc_step_shift = st.gc_mode[rx_meter_pkg::GC_ADAPT_GAIN] ?
                            rx_meter_pkg::GC_STEP_FAST : rx_meter_pkg::STEP_SLOW;

    next_st.eq_update_en  = st.eq_mode[rx_meter_pkg::EQ_ADAPT_COEFF];
    next_st.eq_clear      = st.eq_mode[rx_meter_pkg::EQ_ADAPT_COEFF] &
                            st.eq_mode[rx_meter_pkg::EQ_ZERO_COEFF];
    next_st.eq_last_only  = st.eq_mode[rx_meter_pkg::EQ_ADAPT_COEFF] &
                            st.eq_mode[rx_meter_pkg::EQ_LAST_COEFF];
    next_st.eq_step_shift = st.eq_mode[rx_meter_pkg::EQ_ADAPT_GAIN] ?
                            rx_meter_pkg::EQ_STEP_FAST : rx_meter_pkg::STEP_SLOW;

    next_st.ep_corr_out = st.ep_mode[rx_meter_pkg::EP_ZERO_OUTPUT] ? '0 : ep_corr_in;
    next_st.ep_update_en = st.ep_mode[rx_meter_pkg::EP_ADAPT_COEFF];
    next_st.ep_clear = st.ep_mode[rx_meter_pkg::EP_ADAPT_COEFF] &
                       st.ep_mode[rx_meter_pkg::EP_ZERO_COEFF];
    next_st.ep_step_shift = st.ep_mode[rx_meter_pkg::EP_ADAPT_GAIN] ?
                            rx_meter_pkg::EP_STEP_FAST : rx_meter_pkg::STEP_SLOW;

    if (sym_en) begin
      next_st.phase_acc  = st.phase_acc + phase_add;
      next_st.offset_acc = st.offset_acc + sext_level(rx_sample);
      next_st.mag_acc    = st.mag_acc + mag_add;
      next_st.remote_acc = st.remote_acc + remote_add;
    end
    if (adc_overflow && st.clip_acc != rx_meter_pkg::CLIP_MAX) begin
      next_st.clip_acc = st.clip_acc + 1'b1;
    end

    // interval end loads meters and restarts sums
    if (meter_load) begin
      next_st.phase_mtr  = st.phase_acc;
      next_st.clip_mtr   = st.clip_acc;
      next_st.offset_mtr = st.offset_acc;
      next_st.mag_mtr    = st.mag_acc;
      next_st.remote_mtr = st.remote_acc;
      next_st.phase_acc  = sym_en ? phase_add : '0;
      next_st.offset_acc = sym_en ? sext_level(rx_sample) : '0;
      next_st.mag_acc    = sym_en ? mag_add : '0;
      next_st.remote_acc = sym_en ? remote_add : '0;
      next_st.clip_acc   = adc_overflow ? CW'(1) : '0;
    end

    // Read data; high bytes come from the snapshot so a load between halves is harmless
    if (rd_en) begin
      case (addr)
        rx_meter_pkg::ADDR_PEAK_PATH_DELAY:    next_st.rd_data = 8'(st.delay);
        rx_meter_pkg::ADDR_GAIN_CONTROL_MODES: next_st.rd_data = 8'(st.gc_mode);
        rx_meter_pkg::ADDR_EQUALIZER_MODES:    next_st.rd_data = 8'(st.eq_mode);
        rx_meter_pkg::ADDR_PREDICTOR_MODES:    next_st.rd_data = 8'(st.ep_mode);
        rx_meter_pkg::ADDR_ADC_CLIP_COUNT:     next_st.rd_data = st.clip_mtr;
        rx_meter_pkg::ADDR_PHASE_METER_LO: begin
          next_st.rd_data = st.phase_mtr[rx_meter_pkg::PHASE_LSB +: 8];
          next_st.hi_snap = meter_hi(st, rx_meter_pkg::MTR_PHASE);
        end
        rx_meter_pkg::ADDR_OFFSET_METER_LO: begin
          next_st.rd_data = st.offset_mtr[rx_meter_pkg::LEVEL_LSB +: 8];
          next_st.hi_snap = meter_hi(st, rx_meter_pkg::MTR_OFFSET);
        end
        rx_meter_pkg::ADDR_MAGNITUDE_METER_LO: begin
          next_st.rd_data = st.mag_mtr[rx_meter_pkg::LEVEL_LSB +: 8];
          next_st.hi_snap = meter_hi(st, rx_meter_pkg::MTR_MAG);
        end
        rx_meter_pkg::ADDR_REMOTE_LEVEL_METER_LO: begin
          next_st.rd_data = st.remote_mtr[rx_meter_pkg::LEVEL_LSB +: 8];
          next_st.hi_snap = meter_hi(st, rx_meter_pkg::MTR_REMOTE);
        end
        rx_meter_pkg::ADDR_PHASE_METER_HI,
        rx_meter_pkg::ADDR_OFFSET_METER_HI,
        rx_meter_pkg::ADDR_MAGNITUDE_METER_HI,
        rx_meter_pkg::ADDR_REMOTE_LEVEL_METER_HI: next_st.rd_data = st.hi_snap;
        default: next_st.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st         <= '0;
      st.delay   <= rx_meter_pkg::DELAY_RESET;
      st.gc_mode <= rx_meter_pkg::MODE_RESET;
      st.eq_mode <= rx_meter_pkg::MODE_RESET;
      st.ep_mode <= rx_meter_pkg::MODE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data       = st.rd_data;
  assign peak_out      = st.peak_out;
  assign gc_err        = st.gc_err;
  assign gc_update_en  = st.gc_update_en;
  assign gc_step_shift = st.gc_step_shift;
  assign eq_update_en  = st.eq_update_en;
  assign eq_clear      = st.eq_clear;
  assign eq_last_only  = st.eq_last_only;
  assign eq_step_shift = st.eq_step_shift;
  assign ep_corr_out   = st.ep_corr_out;
  assign ep_update_en  = st.ep_update_en;
  assign ep_clear      = st.ep_clear;
  assign ep_step_shift = st.ep_step_shift;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_lo_read;
    rd_en && addr == rx_meter_pkg::ADDR_PHASE_METER_LO;
  endsequence
  sequence s_hi_read;
    rd_en && addr == rx_meter_pkg::ADDR_PHASE_METER_HI && !meter_load;
  endsequence
  // Symbol strobe with no write that could move the tap
  sequence s_sym_steady;
    sym_en && !wr_en;
  endsequence

  AST_PEAK_ZERO_DELAY: assert property (
      sym_en && st.delay == '0 |=> peak_out == $past(peak_in))
    else $error("peak path not direct at zero delay");
  AST_PEAK_TWO_DELAY: assert property (
      st.delay == 4'h2 ##0 s_sym_steady ##1 s_sym_steady ##1 s_sym_steady
      |=> peak_out == $past(peak_in, 3))
    else $error("peak path delay of two symbols wrong");
  AST_GC_SOURCE: assert property (
      st.gc_mode[rx_meter_pkg::GC_EQ_ERR_SOURCE] |=> gc_err == $past(eq_err))
    else $error("gain-control error not from equalizer");
  AST_GC_FREEZE: assert property (
      !st.gc_mode[rx_meter_pkg::GC_ADAPT_COEFF] |=> !gc_update_en)
    else $error("gain-control coefficients not frozen");
  AST_GC_STEP: assert property (
      $rose(st.gc_mode[rx_meter_pkg::GC_ADAPT_GAIN]) |=> gc_step_shift == 2'h3)
    else $error("gain-control step not times eight");
  AST_EP_BYPASS: assert property (
      st.ep_mode[rx_meter_pkg::EP_ZERO_OUTPUT] |=> ep_corr_out == '0
      && ep_update_en == $past(st.ep_mode[rx_meter_pkg::EP_ADAPT_COEFF]))
    else $error("predictor bypass wrong");
  AST_EP_CLEAR: assert property (
      ep_clear |-> $past(st.ep_mode[rx_meter_pkg::EP_ADAPT_COEFF]))
    else $error("predictor cleared while adaptation off");
  AST_EP_FREEZE: assert property (
      !st.ep_mode[rx_meter_pkg::EP_ADAPT_COEFF] |=> !ep_update_en && !ep_clear)
    else $error("predictor coefficients not frozen");
  AST_EP_STEP: assert property (
      st.ep_mode[rx_meter_pkg::EP_ADAPT_GAIN] |=> ep_step_shift == 2'h2)
    else $error("predictor step not times four");
  AST_METER_LOAD: assert property (
      meter_load |=> st.phase_mtr == $past(st.phase_acc)
      && st.remote_mtr == $past(st.remote_acc))
    else $error("meter not loaded at interval end");
  AST_CLIP_SAT: assert property (
      st.clip_acc == 8'hff && !meter_load |=> st.clip_acc == 8'hff)
    else $error("overflow count wrapped");
  // Halves one idle cycle apart, so no other low read slips in
  AST_PAIR_READ: assert property (
      s_lo_read ##1 !rd_en ##1 s_hi_read |=> rd_data == $past(st.phase_mtr[25:18], 3))
    else $error("high byte not from snapshot");
endmodule : rx_adapt_modes_and_meters
`default_nettype wire

// ===== rx_adapt_modes_and_meters_bench.sv
// Self-checking bench for the receive mode registers and meters
`timescale 1ns/1ps
`default_nettype none
module rx_adapt_modes_and_meters_bench;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr, wr_data, rd_data, v, ovf;
  logic        wr_en, rd_en, sym_en, meter_load, adc_overflow, o;
  logic [15:0] peak_in, peak_out, eq_err, gc_out, gc_target, gc_err;
  logic [15:0] ep_corr_in, ep_corr_out, phase_det, rx_sample, post_ec_sample, a, b, c;
  logic        gc_update_en, eq_update_en, eq_clear, eq_last_only, ep_update_en, ep_clear;
  logic [1:0]  gc_step_shift, eq_step_shift, ep_step_shift;
  logic [25:0] ph;
  logic [31:0] dc, mg, rm;
  logic [15:0] hist[$];
  int          fail_count = 0;
  int          samples_checked = 0;
  int          seed = 32'hee790bbf;
  int          dl[3] = '{0, 7 - 3, 15};

  always #2 clk = ~clk;

  rx_adapt_modes_and_meters dut (
    .clk(clk), .nrst(nrst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wr_data(wr_data), .rd_data(rd_data), .sym_en(sym_en), .meter_load(meter_load),
    .peak_in(peak_in), .peak_out(peak_out), .eq_err(eq_err), .gc_out(gc_out),
    .gc_target(gc_target), .gc_err(gc_err), .gc_update_en(gc_update_en),
    .gc_step_shift(gc_step_shift), .eq_update_en(eq_update_en), .eq_clear(eq_clear),
    .eq_last_only(eq_last_only), .eq_step_shift(eq_step_shift),
    .ep_corr_in(ep_corr_in), .ep_corr_out(ep_corr_out), .ep_update_en(ep_update_en),
    .ep_clear(ep_clear), .ep_step_shift(ep_step_shift), .phase_det(phase_det),
    .adc_overflow(adc_overflow), .rx_sample(rx_sample), .post_ec_sample(post_ec_sample)
  );

  function automatic logic [31:0] abs32(input logic [15:0] x);
    return x[15] ? 32'h0 - {16'hffff, x} : {16'h0, x};
  endfunction : abs32

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Each bus task opens with an edge so strobes never toggle twice in one step
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    tick;
    addr = ad;
    wr_data = d;
    wr_en = 1'b1;
    tick;
    wr_en = 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    tick;
    addr = ad;
    rd_en = 1'b1;
    tick;
    rd_en = 1'b0;
    chk({24'h0, rd_data}, exp);
  endtask : rdc

  task automatic ld;
    tick;
    meter_load = 1'b1;
    tick;
    meter_load = 1'b0;
  endtask : ld

  task automatic push(input logic [15:0] pk, input logic [15:0] rx, input logic [15:0] pe,
                      input logic [15:0] pd, input logic ov);
    tick;
    peak_in = pk;
    rx_sample = rx;
    post_ec_sample = pe;
    phase_det = pd;
    adc_overflow = ov;
    sym_en = 1'b1;
    tick;
    sym_en = 1'b0;
    adc_overflow = 1'b0;
  endtask : push

  task automatic summarize;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize;
  end

  initial begin
    {wr_en, rd_en, sym_en, meter_load, adc_overflow} = '0;
    {addr, wr_data} = '0;
    {peak_in, eq_err, gc_out, gc_target, ep_corr_in, phase_det, rx_sample, post_ec_sample} = '0;
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    for (int r = 8'h3b; r <= 8'h3e; r++) rdc(8'(r), 0);
    chk(peak_out, 0);
    wr(8'h3f, 8'hff);
    rdc(8'h3f, 0);
    rdc(8'h43, 0);
    wr(rx_meter_pkg::ADDR_ADC_CLIP_COUNT, 8'hff);
    rdc(rx_meter_pkg::ADDR_ADC_CLIP_COUNT, 0);
    // Every mode code, upper nibble random to prove it is dropped
    for (int i = 0; i < 16; i++) begin
      v = {4'($random(seed)), 4'(i)};
      wr(rx_meter_pkg::ADDR_GAIN_CONTROL_MODES, v);
      wr(rx_meter_pkg::ADDR_EQUALIZER_MODES, v);
      wr(rx_meter_pkg::ADDR_PREDICTOR_MODES, v);
      eq_err = 16'($random(seed));
      gc_out = (i == 0) ? 16'h8000 : 16'($random(seed));
      gc_target = 16'($random(seed));
      ep_corr_in = 16'($random(seed));
      repeat (3) tick;
      chk(gc_err, v[2] ? eq_err : 16'(16'(abs32(gc_out)) - gc_target));
      chk(gc_update_en, v[1]);
      chk(gc_step_shift, {2{v[0]}});
      chk(ep_corr_out, v[3] ? 16'h0 : ep_corr_in);
      chk(ep_clear, v[1] & v[2]);
      chk(ep_update_en, v[1]);
      chk(ep_step_shift, {v[0], 1'b0});
      chk({eq_update_en, eq_clear, eq_last_only}, {v[1], v[1] & v[2], v[1] & v[3]});
      chk(eq_step_shift, {v[0], 1'b0});
      rdc(rx_meter_pkg::ADDR_GAIN_CONTROL_MODES, v[3:0]);
      rdc(rx_meter_pkg::ADDR_EQUALIZER_MODES, v[3:0]);
      rdc(rx_meter_pkg::ADDR_PREDICTOR_MODES, v[3:0]);
    end
    // Delay settings zero, the default formula value and the maximum
    for (int k = 0; k < 3; k++) begin
      wr(rx_meter_pkg::ADDR_PEAK_PATH_DELAY, {4'ha, 4'(dl[k])});
      rdc(rx_meter_pkg::ADDR_PEAK_PATH_DELAY, dl[k]);
      hist.delete();
      for (int n = 0; n < 24; n++) begin
        hist.push_back(16'($random(seed)));
        push(hist[n], 16'($random(seed)), 16'($random(seed)), 16'($random(seed)), 1'b0);
        tick;
        if (n >= 16) chk(peak_out, hist[n - dl[k]]);
      end
    end
    // Back-to-back symbols at delay two
    wr(rx_meter_pkg::ADDR_PEAK_PATH_DELAY, 8'h02);
    hist.delete();
    sym_en = 1'b1;
    for (int n = 0; n < 8; n++) begin
      hist.push_back(16'($random(seed)));
      peak_in = hist[n];
      tick;
      if (n >= 2) chk(peak_out, hist[n - 2]);
    end
    sym_en = 1'b0;
    ld;
    {ph, dc, mg, rm, ovf} = '0;
    for (int n = 0; n < 150; n++) begin
      a = (n == 0) ? 16'h8000 : 16'($random(seed));
      b = 16'($random(seed));
      c = (n == 1) ? 16'h8000 : 16'($random(seed));
      o = 1'($random(seed));
      push(16'($random(seed)), a, b, c, o);
      ph = ph + {{10{c[15]}}, c};
      dc = dc + {{16{a[15]}}, a};
      mg = mg + abs32(a);
      rm = rm + abs32(b);
      ovf = ovf + 8'(o);
    end
    ld;
    rdc(rx_meter_pkg::ADDR_PHASE_METER_LO, ph[17:10]);
    rdc(rx_meter_pkg::ADDR_PHASE_METER_HI, ph[25:18]);
    rdc(rx_meter_pkg::ADDR_OFFSET_METER_LO, dc[23:16]);
    rdc(rx_meter_pkg::ADDR_OFFSET_METER_HI, dc[31:24]);
    rdc(rx_meter_pkg::ADDR_MAGNITUDE_METER_LO, mg[23:16]);
    rdc(rx_meter_pkg::ADDR_MAGNITUDE_METER_HI, mg[31:24]);
    rdc(rx_meter_pkg::ADDR_REMOTE_LEVEL_METER_LO, rm[23:16]);
    rdc(rx_meter_pkg::ADDR_REMOTE_LEVEL_METER_HI, rm[31:24]);
    rdc(rx_meter_pkg::ADDR_ADC_CLIP_COUNT, ovf);
    // A reload between the two halves must not tear the pair
    rdc(rx_meter_pkg::ADDR_PHASE_METER_LO, ph[17:10]);
    ld;
    rdc(rx_meter_pkg::ADDR_PHASE_METER_HI, ph[25:18]);
    rdc(rx_meter_pkg::ADDR_PHASE_METER_LO, 0);
    rdc(rx_meter_pkg::ADDR_ADC_CLIP_COUNT, 0);
    tick;
    adc_overflow = 1'b1;
    repeat (300) tick;
    adc_overflow = 1'b0;
    ld;
    rdc(rx_meter_pkg::ADDR_ADC_CLIP_COUNT, 8'hff);
    summarize;
  end
endmodule : rx_adapt_modes_and_meters_bench
`default_nettype wire

// ===== rx_meter_pkg.sv
// Register map and field layout of the receive mode and meter registers
`default_nettype none
package rx_meter_pkg;
  localparam logic [7:0] ADDR_PEAK_PATH_DELAY      = 8'h3b;
  localparam logic [7:0] ADDR_GAIN_CONTROL_MODES   = 8'h3c;
  localparam logic [7:0] ADDR_EQUALIZER_MODES      = 8'h3d;
  localparam logic [7:0] ADDR_PREDICTOR_MODES      = 8'h3e;
  localparam logic [7:0] ADDR_PHASE_METER_LO       = 8'h40;
  localparam logic [7:0] ADDR_PHASE_METER_HI       = 8'h41;
  localparam logic [7:0] ADDR_ADC_CLIP_COUNT       = 8'h42;
  localparam logic [7:0] ADDR_OFFSET_METER_LO      = 8'h44;
  localparam logic [7:0] ADDR_OFFSET_METER_HI      = 8'h45;
  localparam logic [7:0] ADDR_MAGNITUDE_METER_LO   = 8'h46;
  localparam logic [7:0] ADDR_MAGNITUDE_METER_HI   = 8'h47;
  localparam logic [7:0] ADDR_REMOTE_LEVEL_METER_LO = 8'h48;
  localparam logic [7:0] ADDR_REMOTE_LEVEL_METER_HI = 8'h49;

  // Field positions in the mode registers
  localparam int GC_ADAPT_GAIN    = 0;
  localparam int GC_ADAPT_COEFF   = 1;
  localparam int GC_EQ_ERR_SOURCE = 2;
  localparam int EQ_ADAPT_GAIN    = 0;
  localparam int EQ_ADAPT_COEFF   = 1;
  localparam int EQ_ZERO_COEFF    = 2;
  localparam int EQ_LAST_COEFF    = 3;
  localparam int EP_ADAPT_GAIN    = 0;
  localparam int EP_ADAPT_COEFF   = 1;
  localparam int EP_ZERO_COEFF    = 2;
  localparam int EP_ZERO_OUTPUT   = 3;

  localparam int MODE_W    = 4;
  localparam int DELAY_W   = 4;
  localparam int PHASE_W   = 26;
  localparam int PHASE_LSB = 10;
  localparam int LEVEL_W   = 32;
  localparam int LEVEL_LSB = 16;
  localparam int CLIP_W    = 8;

  localparam logic [MODE_W-1:0]  MODE_RESET  = 4'h0;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 4'h0;
  localparam logic [CLIP_W-1:0]  CLIP_MAX    = 8'hff;

  // Step shifts: x8 is three bits, x4 is two bits
  localparam logic [1:0] GC_STEP_FAST = 2'h3;
  localparam logic [1:0] EQ_STEP_FAST = 2'h2;
  localparam logic [1:0] EP_STEP_FAST = 2'h2;
  localparam logic [1:0] STEP_SLOW    = 2'h0;

  // Meter selectors for the two-byte read snapshot
  typedef enum logic [1:0] {
    MTR_PHASE  = 2'b00,
    MTR_OFFSET = 2'b01,
    MTR_MAG    = 2'b10,
    MTR_REMOTE = 2'b11
  } meter_e;
endpackage : rx_meter_pkg
`default_nettype wire
